// ===== include/mpt_pkg.sv
// Behaviour
// - 32-bit count behind a 32-bit prescaler
// - count clock or selected capture input edges
// - seven match values, six PWM outputs
// - per match: continue, stop or reset, flag
// - PWM mode: cycle-period match resets count
// - single-edge output rises at cycle start
// - constant-low output never rises at start
// - single uses one match, double two
// - double-edge: one match sets, next clears
// - double-edge edges anywhere in the cycle
// - any period and width, shared rate
// - PWM mode: released match values applied at cycle start
// - capture copies count on input edge
// - two timed DMA requests from matches
package mpt_pkg;
	localparam int unsigned N_MATCH = 7;
	localparam int unsigned N_CAP = 2;
	localparam int unsigned N_PWM = 6;
	localparam int unsigned N_EXT = 4;
	localparam int unsigned N_DMA = 2;
	localparam int unsigned N_FLAG = 10;
	// byte offsets
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_PRESC = 8'h0C;
	localparam logic [7:0] OFS_PCNT = 8'h10;
	localparam logic [7:0] OFS_MCTL = 8'h14;
	localparam logic [7:0] OFS_CCTL = 8'h18;
	localparam logic [7:0] OFS_CSRC = 8'h1C;
	localparam logic [7:0] OFS_PWMC = 8'h20;
	localparam logic [7:0] OFS_LATCH = 8'h24;
	localparam logic [7:0] OFS_EXTM = 8'h28;
	localparam logic [7:0] OFS_DMAC = 8'h2C;
	localparam logic [7:0] OFS_CAP0 = 8'h30;
	localparam logic [7:0] OFS_STAT = 8'h38;
	localparam logic [7:0] OFS_MR0 = 8'h40;
	// field positions
	localparam int unsigned CTRL_EN = 0;
	localparam int unsigned CTRL_RST = 1;
	localparam int unsigned CTRL_PWM = 3;
	localparam logic [3:0] CTRL_MASK = 4'hB;
	localparam int unsigned MCTL_W = 3;
	localparam int unsigned MC_INT = 0;
	localparam int unsigned MC_RST = 1;
	localparam int unsigned MC_STOP = 2;
	localparam int unsigned CC_W = 3;
	localparam int unsigned CC_RISE = 0;
	localparam int unsigned CC_FALL = 1;
	localparam int unsigned CC_INT = 2;
	localparam int unsigned CSRC_SEL = 2;
	localparam logic [1:0] CS_TIMER = 2'h0;
	localparam logic [1:0] CS_RISE = 2'h1;
	localparam logic [1:0] CS_FALL = 2'h2;
	localparam logic [1:0] CS_BOTH = 2'h3;
	localparam int unsigned PWMC_DBL = 1;
	localparam int unsigned PWMC_OEN = 9;
	localparam logic [14:0] PWMC_MASK = 15'h7E7C;
	localparam int unsigned EXT_CTL0 = 4;
	localparam logic [1:0] EM_NONE = 2'h0;
	localparam logic [1:0] EM_LOW = 2'h1;
	localparam logic [1:0] EM_HIGH = 2'h2;
	localparam logic [1:0] EM_TOG = 2'h3;
	localparam int unsigned DMA_W = 4;
	localparam int unsigned DMA_EN = 3;
	localparam int unsigned FLAG_CAP0 = 8;
	localparam logic [2:0] SZ_WORD = 3'h2;
	// values after reset
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {
		BS_READY = 2'b01,
		BS_RWAIT = 2'b10
	} mpt_bus_type;
	localparam mpt_bus_type RST_BST = BS_READY;
endpackage

// ===== include/mpt_pwm_if.sv
`timescale 1ns/1ps
interface mpt_pwm_if;
	logic [mpt_pkg::N_MATCH-1:0] match;
	logic cyc_start;
	logic [mpt_pkg::N_PWM:1] dbl;
	logic [mpt_pkg::N_PWM:1] oen;
	logic [mpt_pkg::N_PWM:1] lowc;
	logic [mpt_pkg::N_PWM:1] pwm;
	modport core (output match, cyc_start, dbl, oen, lowc, input pwm);
	modport outs (input match, cyc_start, dbl, oen, lowc, output pwm);
endinterface

// ===== verilog/mpt_sync.sv
`timescale 1ns/1ps
module mpt_sync (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pins and filtered edges
	input wire logic [mpt_pkg::N_CAP-1:0] din,
	output logic [mpt_pkg::N_CAP-1:0] rise,
	output logic [mpt_pkg::N_CAP-1:0] fall
);
	typedef struct packed {
		logic [mpt_pkg::N_CAP-1:0] s1;
		logic [mpt_pkg::N_CAP-1:0] s2;
		logic [mpt_pkg::N_CAP-1:0] s3;
		logic [mpt_pkg::N_CAP-1:0] lvl;
		logic [mpt_pkg::N_CAP-1:0] rise;
		logic [mpt_pkg::N_CAP-1:0] fall;
	} mpt_sync_st_type;
	mpt_sync_st_type st, nx;
	logic [mpt_pkg::N_CAP-1:0] chg;
	// s1 only feeds s2; a level counts once s2 and s3 agree
	always_comb begin
		nx = st;
		nx.s1 = din;
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		chg = ~(st.s2 ^ st.s3) & (st.s3 ^ st.lvl);
		nx.lvl = st.lvl ^ chg;
		nx.rise = chg & st.s3;
		nx.fall = chg & ~st.s3;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end
	assign rise = st.rise;
	assign fall = st.fall;
endmodule

// ===== verilog/mpt_pwm.sv
`timescale 1ns/1ps
module mpt_pwm (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// events from the counter
	mpt_pwm_if.outs pif
);
	typedef struct packed {
		logic [mpt_pkg::N_PWM:1] pwm;
	} mpt_pwm_st_type;
	mpt_pwm_st_type st, nx;
	logic [mpt_pkg::N_PWM:1] ch_nxt;
	genvar ch;
	generate
		for (ch = 1; ch <= mpt_pkg::N_PWM; ch++) begin : g_ch
			logic set;
			logic clr;
			// double: previous match sets, own match clears
			assign set = pif.dbl[ch] ? pif.match[ch-1] : pif.cyc_start & ~pif.lowc[ch];
			// clear wins so equal edges give a flat line
			assign clr = pif.match[ch];
			assign ch_nxt[ch] = pif.oen[ch] & ~clr & (set | st.pwm[ch]);
		end
	endgenerate
	always_comb begin
		nx = st;
		nx.pwm = ch_nxt;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end
	assign pif.pwm = st.pwm;
endmodule

// ===== verilog/mpt_core.sv
`timescale 1ns/1ps
module mpt_core (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// capture and count inputs
	input wire logic [mpt_pkg::N_CAP-1:0] cap_in,
	// pulse outputs
	output logic [mpt_pkg::N_PWM:1] pwm_out,
	output logic [mpt_pkg::N_EXT-1:0] ext_match,
	output logic [mpt_pkg::N_DMA-1:0] dma_req
);
	typedef struct packed {
		mpt_pkg::mpt_bus_type bst;
		logic hready;
		logic hresp;
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] addr;
		logic [31:0] tc;
		logic [31:0] pc;
		logic [31:0] pr;
		logic [3:0] ctrl;
		logic [mpt_pkg::N_MATCH*mpt_pkg::MCTL_W-1:0] mctl;
		logic [mpt_pkg::N_CAP*mpt_pkg::CC_W-1:0] cctl;
		logic [2:0] csrc;
		logic [14:0] pwmc;
		logic [mpt_pkg::N_MATCH-1:0] ler;
		logic [11:0] emr;
		logic [mpt_pkg::N_DMA*mpt_pkg::DMA_W-1:0] dmac;
		logic [mpt_pkg::N_FLAG-1:0] flags;
		logic [mpt_pkg::N_MATCH-1:0][31:0] mr_sh;
		logic [mpt_pkg::N_MATCH-1:0][31:0] mr_act;
		logic [mpt_pkg::N_CAP-1:0][31:0] cr;
		logic [mpt_pkg::N_DMA-1:0] dma;
	} mpt_core_st_type;

	mpt_core_st_type st, nx;
	logic [mpt_pkg::N_CAP-1:0] cap_rise;
	logic [mpt_pkg::N_CAP-1:0] cap_fall;
	logic [mpt_pkg::N_CAP-1:0] cev;
	logic [mpt_pkg::N_MATCH-1:0] hit;
	logic [mpt_pkg::N_MATCH-1:0] rmask;
	logic [mpt_pkg::N_MATCH-1:0] smask;
	logic [mpt_pkg::N_FLAG-1:0] fset;
	logic [mpt_pkg::N_FLAG-1:0] fclr;
	logic [31:0] rv;
	logic [2:0] dsel;
	logic [1:0] ectl;
	logic pwm_en;
	logic inc_evt;
	logic tick;
	logic cyc;
	logic take;

	mpt_pwm_if pif ();

	mpt_sync u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.din(cap_in),
		.rise(cap_rise),
		.fall(cap_fall)
	);

	mpt_pwm u_pwm (
		.hclk(hclk),
		.hresetn(hresetn),
		.pif(pif)
	);

	always_comb begin
		nx = st;
		fset = '0;
		fclr = '0;
		rv = mpt_pkg::RST_WORD;
		dsel = 3'h0;
		ectl = mpt_pkg::EM_NONE;
		cev = '0;
		nx.dma = '0;
		pwm_en = st.ctrl[mpt_pkg::CTRL_PWM];

		// count source: clock, or filtered edges of one input
		unique case (st.csrc[1:0])
			mpt_pkg::CS_TIMER: begin
				inc_evt = 1'b1;
			end
			mpt_pkg::CS_RISE: begin
				inc_evt = cap_rise[st.csrc[mpt_pkg::CSRC_SEL]];
			end
			mpt_pkg::CS_FALL: begin
				inc_evt = cap_fall[st.csrc[mpt_pkg::CSRC_SEL]];
			end
			mpt_pkg::CS_BOTH: begin
				inc_evt = cap_rise[st.csrc[mpt_pkg::CSRC_SEL]]
					| cap_fall[st.csrc[mpt_pkg::CSRC_SEL]];
			end
		endcase

		// count advances when the prescaler wraps
		tick = st.ctrl[mpt_pkg::CTRL_EN] & ~st.ctrl[mpt_pkg::CTRL_RST]
			& inc_evt & (st.pc == st.pr);

		// match compare against the active copies
		for (int i = 0; i < mpt_pkg::N_MATCH; i++) begin
			hit[i] = tick & (st.tc == st.mr_act[i]);
			rmask[i] = st.mctl[mpt_pkg::MCTL_W*i+mpt_pkg::MC_RST];
			smask[i] = st.mctl[mpt_pkg::MCTL_W*i+mpt_pkg::MC_STOP];
			fset[i] = hit[i] & st.mctl[mpt_pkg::MCTL_W*i+mpt_pkg::MC_INT];
		end
		// in pwm mode the period match always wraps the count
		rmask[0] = rmask[0] | pwm_en;
		cyc = pwm_en & hit[0];

		// prescaler and counter
		if (st.ctrl[mpt_pkg::CTRL_RST]) begin
			nx.pc = mpt_pkg::RST_WORD;
			nx.tc = mpt_pkg::RST_WORD;
		end else if (st.ctrl[mpt_pkg::CTRL_EN] && inc_evt) begin
			if (st.pc == st.pr) begin
				nx.pc = mpt_pkg::RST_WORD;
				if (|(hit & rmask)) begin
					nx.tc = mpt_pkg::RST_WORD;
				end else begin
					nx.tc = st.tc + 32'h0000_0001;
				end
			end else begin
				nx.pc = st.pc + 32'h0000_0001;
			end
		end
		// stop clears the enable; the count still steps once past the match
		if (|(hit & smask)) begin
			nx.ctrl[mpt_pkg::CTRL_EN] = 1'b0;
		end

		// match values: direct in timer mode, released ones at cycle start in pwm mode
		if (!pwm_en) begin
			nx.mr_act = st.mr_sh;
		end else if (cyc) begin
			for (int i = 0; i < mpt_pkg::N_MATCH; i++) begin
				if (st.ler[i]) begin
					nx.mr_act[i] = st.mr_sh[i];
				end
			end
			nx.ler = '0;
		end

		// external match outputs
		for (int e = 0; e < mpt_pkg::N_EXT; e++) begin
			ectl = st.emr[mpt_pkg::EXT_CTL0+2*e +: 2];
			if (hit[e]) begin
				unique case (ectl)
					mpt_pkg::EM_NONE: begin
						nx.emr[e] = st.emr[e];
					end
					mpt_pkg::EM_LOW: begin
						nx.emr[e] = 1'b0;
					end
					mpt_pkg::EM_HIGH: begin
						nx.emr[e] = 1'b1;
					end
					mpt_pkg::EM_TOG: begin
						nx.emr[e] = ~st.emr[e];
					end
				endcase
			end
		end

		// capture on selected edges of each input
		for (int c = 0; c < mpt_pkg::N_CAP; c++) begin
			cev[c] = (st.cctl[mpt_pkg::CC_W*c+mpt_pkg::CC_RISE] & cap_rise[c])
				| (st.cctl[mpt_pkg::CC_W*c+mpt_pkg::CC_FALL] & cap_fall[c]);
			if (cev[c]) begin
				nx.cr[c] = st.tc;
			end
			fset[mpt_pkg::FLAG_CAP0+c] = cev[c]
				& st.cctl[mpt_pkg::CC_W*c+mpt_pkg::CC_INT];
		end

		// timed dma requests, one-cycle pulse per selected match
		for (int d = 0; d < mpt_pkg::N_DMA; d++) begin
			dsel = st.dmac[mpt_pkg::DMA_W*d +: 3];
			if (st.dmac[mpt_pkg::DMA_W*d+mpt_pkg::DMA_EN]
				&& dsel < 3'(mpt_pkg::N_MATCH)) begin
				nx.dma[d] = hit[dsel];
			end
		end

		// read mux, sampled from the stored address
		case (st.addr)
			mpt_pkg::OFS_FLAGS: begin
				rv = 32'(st.flags);
			end
			mpt_pkg::OFS_CTRL: begin
				rv = 32'(st.ctrl);
			end
			mpt_pkg::OFS_COUNT: begin
				rv = st.tc;
			end
			mpt_pkg::OFS_PRESC: begin
				rv = st.pr;
			end
			mpt_pkg::OFS_PCNT: begin
				rv = st.pc;
			end
			mpt_pkg::OFS_MCTL: begin
				rv = 32'(st.mctl);
			end
			mpt_pkg::OFS_CCTL: begin
				rv = 32'(st.cctl);
			end
			mpt_pkg::OFS_CSRC: begin
				rv = 32'(st.csrc);
			end
			mpt_pkg::OFS_PWMC: begin
				rv = 32'(st.pwmc);
			end
			mpt_pkg::OFS_LATCH: begin
				rv = 32'(st.ler);
			end
			mpt_pkg::OFS_EXTM: begin
				rv = 32'(st.emr);
			end
			mpt_pkg::OFS_DMAC: begin
				rv = 32'(st.dmac);
			end
			mpt_pkg::OFS_STAT: begin
				rv = 32'({st.ler, st.emr[mpt_pkg::N_EXT-1:0], pif.pwm,
					st.ctrl[mpt_pkg::CTRL_EN]});
			end
			default: begin
				for (int c = 0; c < mpt_pkg::N_CAP; c++) begin
					if (st.addr == 8'(mpt_pkg::OFS_CAP0 + 4*c)) begin
						rv = st.cr[c];
					end
				end
				// reads return the shadow, not the active copy
				for (int i = 0; i < mpt_pkg::N_MATCH; i++) begin
					if (st.addr == 8'(mpt_pkg::OFS_MR0 + 4*i)) begin
						rv = st.mr_sh[i];
					end
				end
			end
		endcase

		// data phase of a write; placed last so software wins over hardware updates except flag sets
		if (st.wr_pend) begin
			case (st.addr)
				mpt_pkg::OFS_FLAGS: begin
					fclr = hwdata[mpt_pkg::N_FLAG-1:0];
				end
				mpt_pkg::OFS_CTRL: begin
					nx.ctrl = hwdata[3:0] & mpt_pkg::CTRL_MASK;
				end
				mpt_pkg::OFS_COUNT: begin
					nx.tc = hwdata;
				end
				mpt_pkg::OFS_PRESC: begin
					nx.pr = hwdata;
				end
				mpt_pkg::OFS_PCNT: begin
					nx.pc = hwdata;
				end
				mpt_pkg::OFS_MCTL: begin
					nx.mctl = hwdata[$bits(st.mctl)-1:0];
				end
				mpt_pkg::OFS_CCTL: begin
					nx.cctl = hwdata[$bits(st.cctl)-1:0];
				end
				mpt_pkg::OFS_CSRC: begin
					nx.csrc = hwdata[2:0];
				end
				mpt_pkg::OFS_PWMC: begin
					// output 1 has no earlier match, so it is single-edge only
					nx.pwmc = hwdata[14:0] & mpt_pkg::PWMC_MASK;
				end
				mpt_pkg::OFS_LATCH: begin
					nx.ler = hwdata[mpt_pkg::N_MATCH-1:0];
				end
				mpt_pkg::OFS_EXTM: begin
					nx.emr = hwdata[11:0];
				end
				mpt_pkg::OFS_DMAC: begin
					nx.dmac = hwdata[$bits(st.dmac)-1:0];
				end
				default: begin
					for (int i = 0; i < mpt_pkg::N_MATCH; i++) begin
						if (st.addr == 8'(mpt_pkg::OFS_MR0 + 4*i)) begin
							nx.mr_sh[i] = hwdata;
						end
					end
				end
			endcase
		end

		// set beats clear in the same cycle
		nx.flags = (st.flags & ~fclr) | fset;

		// bus handshake: writes have no wait, reads one wait so a
		// write just before is already visible
		take = hsel & htrans[1] & hready;
		nx.wr_pend = 1'b0;
		nx.hresp = 1'b0;
		unique case (st.bst)
			mpt_pkg::BS_READY: begin
				if (take) begin
					nx.addr = haddr[7:0];
					if (hwrite) begin
						nx.wr_pend = (hsize == mpt_pkg::SZ_WORD);
					end else begin
						nx.bst = mpt_pkg::BS_RWAIT;
						nx.hready = 1'b0;
					end
				end
			end
			mpt_pkg::BS_RWAIT: begin
				nx.hrdata = rv;
				nx.hready = 1'b1;
				nx.bst = mpt_pkg::BS_READY;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.bst <= mpt_pkg::RST_BST;
			st.hready <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	// pwm output control
	assign pif.match = hit;
	assign pif.cyc_start = cyc;
	assign pif.dbl = st.pwmc[mpt_pkg::PWMC_DBL +: mpt_pkg::N_PWM];
	assign pif.oen = st.pwmc[mpt_pkg::PWMC_OEN +: mpt_pkg::N_PWM] & {mpt_pkg::N_PWM{pwm_en}};
	genvar ch;
	generate
		for (ch = 1; ch <= mpt_pkg::N_PWM; ch++) begin : g_low
			// judged on the value about to become active
			assign pif.lowc[ch] = (nx.mr_act[ch] == mpt_pkg::RST_WORD);
		end
	endgenerate

	assign hrdata = st.hrdata;
	assign hreadyout = st.hready;
	assign hresp = st.hresp;
	assign ext_match = st.emr[mpt_pkg::N_EXT-1:0];
	assign dma_req = st.dma;
	assign pwm_out = pif.pwm;
endmodule

// ===== test/mpt_core_checker.sv
`timescale 1ns/1ps
module mpt_core_checker (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// pins
	input wire logic [mpt_pkg::N_CAP-1:0] cap_in,
	input wire logic [mpt_pkg::N_PWM:1] pwm_out,
	input wire logic [mpt_pkg::N_EXT-1:0] ext_match,
	input wire logic [mpt_pkg::N_DMA-1:0] dma_req
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_t;
	logic wr_t;
	logic ext_t;
	assign rd_t = hsel && htrans[1] && hready && !hwrite;
	assign wr_t = hsel && htrans[1] && hready && hwrite;
	assign ext_t = wr_t && hsize == mpt_pkg::SZ_WORD && haddr[7:0] == mpt_pkg::OFS_EXTM;
	sequence rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence ext_lands;
		##2 ext_match == $past(hwdata[3:0]);
	endsequence
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	a_read_wait: assert property (rd_t |=> rd_answer) else $error("read wait wrong");
	a_write_nowait: assert property (wr_t |=> hreadyout) else $error("write stalled");
	a_wait_single: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
	a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
		else $error("read data moved");
	a_dma0_pulse: assert property (dma_req[0] |=> !dma_req[0]) else $error("dma0 long");
	a_dma1_pulse: assert property (dma_req[1] |=> !dma_req[1]) else $error("dma1 long");
	a_ext_write: assert property (ext_t |-> ext_lands) else $error("ext level lost");
endmodule

bind mpt_core mpt_core_checker i_mpt_core_checker (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .cap_in(cap_in), .pwm_out(pwm_out),
	.ext_match(ext_match), .dma_req(dma_req)
);

// ===== test/mpt_load.sv
`timescale 1ns/1ps
module mpt_load (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// driven pin
	input wire logic pin,
	// last high time and period, cycles
	output int hi_len,
	output int per_len
);
	int cnt;
	logic pin_r;
	// a load only listens, so it measures rather than drives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 0;
			pin_r <= 1'b0;
			hi_len <= 0;
			per_len <= 0;
		end else begin
			pin_r <= pin;
			cnt <= cnt + 1;
			if (pin && !pin_r) begin
				per_len <= cnt;
				cnt <= 1;
			end
			if (!pin && pin_r) begin
				hi_len <= cnt;
			end
		end
	end
endmodule

// ===== test/mpt_core_test.sv
`timescale 1ns/1ps
module mpt_core_test;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = mpt_pkg::SZ_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [1:0] cap_in = 2'h0;
	logic [6:1] pwm_out;
	logic [3:0] ext_match;
	logic [1:0] dma_req;
	logic [31:0] q;
	int hi1, per1, hi2, per2, hn;
	int miscompares = 0;
	int cmp_count = 0;
	int dma_n = 0;
	int dma_m = 0;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} mpt_row_type;
	mpt_row_type rows [6] = '{
		'{mpt_pkg::OFS_PRESC, 32'hA5A5_A5A5, 32'hA5A5_A5A5},
		'{mpt_pkg::OFS_CTRL, 32'h0000_000E, 32'h0000_000A},
		'{mpt_pkg::OFS_PWMC, 32'h0000_FFFF, 32'h0000_7E7C},
		'{8'h58, 32'h1234_5678, 32'h1234_5678},
		'{8'h3C, 32'hFFFF_FFFF, 32'h0},
		'{8'hFC, 32'hFFFF_FFFF, 32'h0}};
	initial forever #2.5 hclk = ~hclk;
	mpt_core i_mpt_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cap_in(cap_in), .pwm_out(pwm_out), .ext_match(ext_match), .dma_req(dma_req));
	mpt_load i_mpt_load_a (.hclk(hclk), .hresetn(hresetn), .pin(pwm_out[1]),
		.hi_len(hi1), .per_len(per1));
	mpt_load i_mpt_load_b (.hclk(hclk), .hresetn(hresetn), .pin(pwm_out[2]),
		.hi_len(hi2), .per_len(per2));
	always @(posedge hclk) if (dma_req[0] === 1'b1) dma_n++;
	always @(posedge hclk) if (dma_req[1] === 1'b1) dma_m++;
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(0, mpt_pkg::OFS_FLAGS, 0);
		chk(q, mpt_pkg::RST_WORD);
		foreach (rows[i]) begin
			ahb(1, rows[i].a, rows[i].d);
			ahb(0, rows[i].a, 0);
			chk(q, rows[i].e);
		end
		$display("registers done");
		@(posedge hclk) hresetn <= 1'b0;
		@(posedge hclk) hresetn <= 1'b1;
		ahb(0, mpt_pkg::OFS_PRESC, 0);
		chk(q, mpt_pkg::RST_WORD);
		ahb(1, mpt_pkg::OFS_CSRC, 32'h1);
		ahb(1, mpt_pkg::OFS_CTRL, 32'h1);
		repeat (5) begin
			repeat (4) @(posedge hclk);
			cap_in <= 2'h1;
			repeat (4) @(posedge hclk);
			cap_in <= 2'h0;
		end
		repeat (8) @(posedge hclk);
		ahb(0, mpt_pkg::OFS_COUNT, 0);
		chk(q, 32'h5);
		// second input: falling edges only, then both edges
		for (int m = 6; m < 8; m++) begin
			ahb(1, mpt_pkg::OFS_CSRC, 32'(m));
			repeat (2) begin
				repeat (4) @(posedge hclk);
				cap_in <= 2'h2;
				repeat (4) @(posedge hclk);
				cap_in <= 2'h0;
			end
			repeat (8) @(posedge hclk);
			ahb(0, mpt_pkg::OFS_COUNT, 0);
			chk(q, (m == 6) ? 32'h7 : 32'hB);
		end
		// timer mode again, then one capture edge on channel 0
		ahb(1, mpt_pkg::OFS_CSRC, 32'h0);
		ahb(1, mpt_pkg::OFS_CCTL, 32'h5);
		cap_in <= 2'h1;
		repeat (10) @(posedge hclk);
		ahb(0, mpt_pkg::OFS_CAP0, 0);
		chk({31'h0, q != 32'h0}, 32'h1);
		ahb(0, mpt_pkg::OFS_FLAGS, 0);
		chk(q & 32'h100, 32'h100);
		ahb(1, mpt_pkg::OFS_FLAGS, 32'h100);
		ahb(0, mpt_pkg::OFS_FLAGS, 0);
		chk(q & 32'h100, 32'h0);
		$display("count and capture done");
		ahb(1, mpt_pkg::OFS_CTRL, 32'h2);
		ahb(1, mpt_pkg::OFS_MR0, 32'h3);
		ahb(1, mpt_pkg::OFS_MCTL, 32'h5);
		ahb(1, mpt_pkg::OFS_DMAC, 32'h98);
		for (int c = 0; c < 4; c++) begin
			ahb(1, mpt_pkg::OFS_CTRL, 32'h2);
			ahb(1, mpt_pkg::OFS_EXTM, {26'h0, c[1:0], 4'h1});
			ahb(1, mpt_pkg::OFS_CTRL, 32'h1);
			repeat (20) @(posedge hclk);
			chk({28'h0, ext_match}, {31'h0, ~c[0]});
			ahb(0, mpt_pkg::OFS_CTRL, 0);
			chk(q, 32'h0);
			ahb(0, mpt_pkg::OFS_COUNT, 0);
			chk(q, 32'h4);
		end
		chk(32'(dma_n), 32'h4);
		chk(32'(dma_m), 32'h4);
		ahb(0, mpt_pkg::OFS_FLAGS, 0);
		chk(q & 32'h1, 32'h1);
		$display("stop and outputs done");
		ahb(1, mpt_pkg::OFS_CTRL, 32'h2);
		ahb(1, mpt_pkg::OFS_MCTL, 32'h0);
		ahb(1, mpt_pkg::OFS_MR0, 32'h9);
		ahb(1, mpt_pkg::OFS_MR0 + 8'h4, 32'h4);
		ahb(1, mpt_pkg::OFS_MR0 + 8'h8, 32'h7);
		ahb(1, mpt_pkg::OFS_PWMC, 32'h0000_0604);
		ahb(1, mpt_pkg::OFS_LATCH, 32'h7);
		ahb(1, mpt_pkg::OFS_CTRL, 32'h9);
		repeat (40) @(posedge hclk);
		chk(32'(per1), 32'hA);
		chk(32'(hi1), 32'h5);
		chk(32'(per2), 32'hA);
		chk(32'(hi2), 32'h3);
		// new width held back until released
		ahb(1, mpt_pkg::OFS_MR0 + 8'h4, 32'h2);
		repeat (40) @(posedge hclk);
		chk(32'(hi1), 32'h5);
		ahb(1, mpt_pkg::OFS_LATCH, 32'h2);
		repeat (40) @(posedge hclk);
		chk(32'(hi1), 32'h3);
		ahb(1, mpt_pkg::OFS_MR0 + 8'h4, 32'h0);
		ahb(1, mpt_pkg::OFS_LATCH, 32'h2);
		repeat (30) @(posedge hclk);
		hn = 0;
		// disabled outputs must stay low as well
		repeat (30) @(posedge hclk) if (pwm_out[1] !== 1'b0 || pwm_out[6:3] !== 4'h0) hn++;
		chk(32'(hn), 32'h0);
		$display("pwm done");
		tally_and_finish();
	end
	initial begin
		#40000;
		miscompares++;
		tally_and_finish();
	end
endmodule
